//--- design/pbm_cfg.svh
// Constants of the basic PHY management register bank: addresses, bit positions,
// reset values and management frame counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PBM_CFG_SVH
`define PBM_CFG_SVH

// Management register addresses.
`define PBM_REG_CTRL      5'h00
`define PBM_REG_STAT      5'h01
`define PBM_REG_ID_HIGH   5'h02
`define PBM_REG_ID_LOW    5'h03
`define PBM_REG_EXT_CTRL  5'h0D
`define PBM_REG_EXT_DATA  5'h0E

// Control word bit positions.
`define PBM_CTRL_RST      15
`define PBM_CTRL_LOOP     14
`define PBM_CTRL_SPD_LO   13
`define PBM_CTRL_AN       12
`define PBM_CTRL_PD       11
`define PBM_CTRL_ISO      10
`define PBM_CTRL_DUPLEX   8
`define PBM_CTRL_SPD_HI   6

// Status word bit positions fed from the core.
`define PBM_STAT_AN_DONE  5
`define PBM_STAT_LINK     2

// Reset values.
`define PBM_CTRL_RESET    16'h1100
`define PBM_STAT_BASE     16'h1009
`define PBM_EXT_RESET     16'h0000

// Management frame preamble length and last field counts, in MDC cycles, and opcodes.
`define PBM_PREAMBLE_LEN  6'h20
`define PBM_HDR_LAST      6'h0B
`define PBM_TA_LAST       6'h01
`define PBM_DATA_LAST     6'h0F
`define PBM_SKIP_LAST     6'h11
`define PBM_OP_READ       2'h2
`define PBM_OP_WRITE      2'h1

`endif

//--- design/pbm_pkg.sv
// Types shared by the basic PHY management design files.
// Assumes pbm_cfg.svh is on the include path.
package pbm_pkg;
  `include "pbm_cfg.svh"

  // Phases of one serial management frame.
  typedef enum logic [2:0] {
    PBM_PRE,
    PBM_ST,
    PBM_HDR,
    PBM_TA,
    PBM_DATA,
    PBM_SKIP
  } pbm_state_t;
endpackage

//--- design/pbm_mdio_slave.sv
// Serial management frame engine: decodes read and write frames on MDC/MDIO.
// Assumes MDC and MDIO are synchronous to ref_clk_i and MDC is much slower.
`timescale 1ns/1ps
`include "pbm_cfg.svh"
module pbm_mdio_slave (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [15:0] rd_data_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  output logic [4:0]       reg_addr_o,
  output logic             wr_stb_o,
  output logic [15:0]      wr_data_o
);
  import pbm_pkg::*;

  pbm_state_t  state;
  pbm_state_t  next_state;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [11:0] hdr;
  logic        is_read;
  logic        next_is_read;
  logic        mdc_q;
  logic        rise;
  logic        fall;
  logic        next_mdio;
  logic        next_oe;
  logic [4:0]  next_reg_addr;
  logic        next_wr_stb;
  logic [15:0] next_wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing. Inputs are sampled on MDC rising edges and the read
  // data is launched on falling edges so the station sees it stable.
  assign rise = mdc_i & ~mdc_q;
  assign fall = ~mdc_i & mdc_q;
  assign hdr  = {shift[10:0], mdio_i};

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_is_read  = is_read;
    next_mdio     = mdio_o;
    next_oe       = mdio_oe_o;
    next_reg_addr = reg_addr_o;
    next_wr_stb   = 1'b0;
    next_wr_data  = wr_data_o;
    if (rise) begin
      case (state)
        PBM_PRE: begin
          if (mdio_i) begin
            if (cnt != `PBM_PREAMBLE_LEN) next_cnt = cnt + 6'h01;
          end else if (cnt == `PBM_PREAMBLE_LEN) begin
            next_state = PBM_ST;
            next_cnt   = 6'h00;
          end else begin
            next_cnt = 6'h00;
          end
        end
        PBM_ST: begin
          next_state = mdio_i ? PBM_HDR : PBM_PRE;
          next_cnt   = 6'h00;
        end
        PBM_HDR: begin
          next_shift = {shift[14:0], mdio_i};
          next_cnt   = cnt + 6'h01;
          if (cnt == `PBM_HDR_LAST) begin
            next_cnt      = 6'h00;
            next_reg_addr = hdr[4:0];
            next_is_read  = (hdr[11:10] == `PBM_OP_READ);
            // A frame for another PHY or with a bad opcode is only counted out.
            if (hdr[9:5] == phy_addr_i &&
                (hdr[11:10] == `PBM_OP_READ || hdr[11:10] == `PBM_OP_WRITE)) begin
              next_state = PBM_TA;
            end else begin
              next_state = PBM_SKIP;
            end
          end
        end
        PBM_TA: begin
          next_cnt = cnt + 6'h01;
          if (cnt == `PBM_TA_LAST) begin
            next_state = PBM_DATA;
            next_cnt   = 6'h00;
            if (is_read) next_shift = rd_data_i;
          end
        end
        PBM_DATA: begin
          next_cnt = cnt + 6'h01;
          if (!is_read) next_shift = {shift[14:0], mdio_i};
          if (cnt == `PBM_DATA_LAST) begin
            next_state = PBM_PRE;
            next_cnt   = 6'h00;
            if (!is_read) begin
              next_wr_stb  = 1'b1;
              next_wr_data = {shift[14:0], mdio_i};
            end
          end
        end
        PBM_SKIP: begin
          next_cnt = cnt + 6'h01;
          if (cnt == `PBM_SKIP_LAST) begin
            next_state = PBM_PRE;
            next_cnt   = 6'h00;
          end
        end
        default: begin
          next_state = PBM_PRE;
          next_cnt   = 6'h00;
        end
      endcase
    end
    if (fall) begin
      next_oe   = 1'b0;
      next_mdio = 1'b0;
      if (state == PBM_TA && is_read && cnt == `PBM_TA_LAST) begin
        next_oe = 1'b1; // Second turnaround bit is driven low.
      end else if (state == PBM_DATA && is_read) begin
        next_oe   = 1'b1;
        next_mdio = shift[4'hF - cnt[3:0]];
      end
    end
  end

  // Register stage of the frame engine.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state      <= PBM_PRE;
      cnt        <= 6'h00;
      shift      <= 16'h0000;
      is_read    <= 1'b0;
      mdc_q      <= 1'b0;
      mdio_o     <= 1'b0;
      mdio_oe_o  <= 1'b0;
      reg_addr_o <= 5'h00;
      wr_stb_o   <= 1'b0;
      wr_data_o  <= 16'h0000;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shift      <= next_shift;
      is_read    <= next_is_read;
      mdc_q      <= mdc_i;
      mdio_o     <= next_mdio;
      mdio_oe_o  <= next_oe;
      reg_addr_o <= next_reg_addr;
      wr_stb_o   <= next_wr_stb;
      wr_data_o  <= next_wr_data;
    end
  end
endmodule

//--- design/pbm_phy_basic_mgmt.sv
// Basic management register bank of a single-pair 10 Mbps PHY behind MDIO.
// Assumes the PHY core supplies autoneg state, link state and a reset-done pulse,
// and that all pins are synchronous to ref_clk_i.
// Notes on behaviour
// - control word at address 0, resets to 0x1100
// - identifier words at 0x2, 0x3 are fixed
// - bit 15 starts soft reset, self-clears
// - bit 14 drives PCS loopback enable
// - bit 13 speed low reads zero
// - bit 12 mirrors autoneg enable, read-only
// - bit 11 drives core soft power-down
// - management access works during power-down
// - power-down reset value comes from strap
// - bit 6 speed high reads zero
// - bit 8 duplex always reads one
// - bit 10 isolates PHY from MAC
`timescale 1ns/1ps
`include "pbm_cfg.svh"
module pbm_phy_basic_mgmt #(
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value.
  parameter logic [15:0] ID_LOW  = 16'h5678  // Arbitrary value.
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic        pd_strap_i,
  input  wire logic        autoneg_enable_bit_i,
  input  wire logic        an_complete_i,
  input  wire logic        link_up_i,
  input  wire logic        core_reset_done_i,
  output logic             core_soft_reset_bit_o,
  output logic             pcs_loop_enable_bit_o,
  output logic             core_soft_power_down_bit_o,
  output logic             isolate_o,
  output logic [15:0]      ext_ctrl_o,
  output logic [15:0]      ext_data_o,
  output logic             ext_data_wr_o
);
  import pbm_pkg::*;

  // Reset image of the control word; single bits are taken from it by position.
  localparam logic [15:0] CTRL_RESET = `PBM_CTRL_RESET;

  logic [4:0]  reg_addr;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic        wr_ctrl;
  logic        wr_ext_ctrl;
  logic        wr_ext_data;
  logic        soft_rst;
  logic        next_soft_rst;
  logic        loop_en;
  logic        next_loop_en;
  logic        pd;
  logic        next_pd;
  logic        iso;
  logic        next_iso;
  logic        strap_taken;
  logic        next_strap_taken;
  logic [15:0] ext_ctrl;
  logic [15:0] next_ext_ctrl;
  logic [15:0] ext_data;
  logic [15:0] next_ext_data;
  logic        next_ext_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine; it never looks at power-down, so access survives it.
  pbm_mdio_slave u_mdio (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .mdc_i      (mdc_i),
    .mdio_i     (mdio_i),
    .phy_addr_i (phy_addr_i),
    .rd_data_i  (rd_data),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o),
    .reg_addr_o (reg_addr),
    .wr_stb_o   (wr_stb),
    .wr_data_o  (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.
  assign wr_ctrl     = wr_stb && (reg_addr == `PBM_REG_CTRL);
  assign wr_ext_ctrl = wr_stb && (reg_addr == `PBM_REG_EXT_CTRL);
  assign wr_ext_data = wr_stb && (reg_addr == `PBM_REG_EXT_DATA);

  // Only the writable control bits take write data; the rest are fixed.
  always_comb begin
    next_soft_rst    = soft_rst;
    next_loop_en     = loop_en;
    next_pd          = pd;
    next_iso         = iso;
    next_strap_taken = 1'b1;
    next_ext_ctrl    = ext_ctrl;
    next_ext_data    = ext_data;
    next_ext_wr      = wr_ext_data;
    // A fresh request wins over the done pulse so a back-to-back reset is kept.
    if (core_reset_done_i) next_soft_rst = 1'b0;
    if (wr_ctrl && wr_data[`PBM_CTRL_RST]) next_soft_rst = 1'b1;
    if (wr_ctrl) begin
      next_loop_en = wr_data[`PBM_CTRL_LOOP];
      next_iso     = wr_data[`PBM_CTRL_ISO];
    end
    // The strap is caught on the first edge after reset release.
    if (!strap_taken) begin
      next_pd = pd_strap_i;
    end else if (wr_ctrl) begin
      next_pd = wr_data[`PBM_CTRL_PD];
    end
    if (wr_ext_ctrl) next_ext_ctrl = wr_data;
    if (wr_ext_data) next_ext_data = wr_data;
  end

  // Register stage of the control state.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_rst      <= CTRL_RESET[`PBM_CTRL_RST];
      loop_en       <= CTRL_RESET[`PBM_CTRL_LOOP];
      pd            <= CTRL_RESET[`PBM_CTRL_PD];
      iso           <= CTRL_RESET[`PBM_CTRL_ISO];
      strap_taken   <= 1'b0;
      ext_ctrl      <= `PBM_EXT_RESET;
      ext_data      <= `PBM_EXT_RESET;
      ext_data_wr_o <= 1'b0;
    end else begin
      soft_rst      <= next_soft_rst;
      loop_en       <= next_loop_en;
      pd            <= next_pd;
      iso           <= next_iso;
      strap_taken   <= next_strap_taken;
      ext_ctrl      <= next_ext_ctrl;
      ext_data      <= next_ext_data;
      ext_data_wr_o <= next_ext_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side. Duplex and fixed speed bits are set explicitly over the reset constant.
  always_comb begin
    ctrl_word                  = `PBM_CTRL_RESET;
    ctrl_word[`PBM_CTRL_RST]   = soft_rst;
    ctrl_word[`PBM_CTRL_LOOP]  = loop_en;
    ctrl_word[`PBM_CTRL_SPD_LO] = 1'b0;
    ctrl_word[`PBM_CTRL_AN]    = autoneg_enable_bit_i;
    ctrl_word[`PBM_CTRL_PD]    = pd;
    ctrl_word[`PBM_CTRL_ISO]   = iso;
    ctrl_word[`PBM_CTRL_DUPLEX] = 1'b1;
    ctrl_word[`PBM_CTRL_SPD_HI] = 1'b0;
    stat_word                  = `PBM_STAT_BASE;
    stat_word[`PBM_STAT_AN_DONE] = an_complete_i;
    stat_word[`PBM_STAT_LINK]  = link_up_i;
  end

  // Unmapped addresses read as zero.
  always_comb begin
    case (reg_addr)
      `PBM_REG_CTRL:     rd_data = ctrl_word;
      `PBM_REG_STAT:     rd_data = stat_word;
      `PBM_REG_ID_HIGH:  rd_data = ID_HIGH;
      `PBM_REG_ID_LOW:   rd_data = ID_LOW;
      `PBM_REG_EXT_CTRL: rd_data = ext_ctrl;
      `PBM_REG_EXT_DATA: rd_data = ext_data;
      default:           rd_data = 16'h0000;
    endcase
  end

  // Mirrors toward the PHY core.
  assign core_soft_reset_bit_o      = soft_rst;
  assign pcs_loop_enable_bit_o      = loop_en;
  assign core_soft_power_down_bit_o = pd;
  assign isolate_o                  = iso;
  assign ext_ctrl_o                 = ext_ctrl;
  assign ext_data_o                 = ext_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register bank.
  a_ctrl_reset_word: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!strap_taken && autoneg_enable_bit_i) |-> (ctrl_word == `PBM_CTRL_RESET))
    else $error("Control word differs from its reset value.");
  a_id_fixed: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (reg_addr == `PBM_REG_ID_HIGH) ##1 (reg_addr == `PBM_REG_ID_HIGH)
    |-> (rd_data == ID_HIGH) && $stable(rd_data))
    else $error("Identifier word changed.");
  a_soft_rst_set: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (wr_ctrl && wr_data[`PBM_CTRL_RST]) |=> core_soft_reset_bit_o)
    else $error("Soft reset request was lost.");
  a_soft_rst_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (soft_rst && core_reset_done_i && !wr_ctrl) |=> !ctrl_word[`PBM_CTRL_RST])
    else $error("Soft reset did not clear after the cycle.");
  a_loop_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (pcs_loop_enable_bit_o == $past(wr_data[`PBM_CTRL_LOOP])))
    else $error("Loopback enable did not follow the write.");
  a_speed_low_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 (reg_addr == `PBM_REG_CTRL) |-> !rd_data[`PBM_CTRL_SPD_LO])
    else $error("Speed low bit reads one.");
  a_an_mirror: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (ctrl_word[`PBM_CTRL_AN] == autoneg_enable_bit_i))
    else $error("Autoneg bit does not mirror the core.");
  a_pd_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (wr_ctrl && strap_taken)
    |=> (core_soft_power_down_bit_o == $past(wr_data[`PBM_CTRL_PD])))
    else $error("Power-down did not follow the write.");
  a_pd_serves: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pd && wr_ext_data) |=> (ext_data_o == $past(wr_data)) && ext_data_wr_o)
    else $error("Write lost during power-down.");
  a_pd_strap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(strap_taken) |-> (pd == $past(pd_strap_i)))
    else $error("Power-down did not take the strap.");
  a_fixed_bits: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> ctrl_word[`PBM_CTRL_DUPLEX] && !ctrl_word[`PBM_CTRL_SPD_HI])
    else $error("Duplex or speed high bit was written.");
  a_iso_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (isolate_o == $past(wr_data[`PBM_CTRL_ISO]))
    && ctrl_word[`PBM_CTRL_DUPLEX])
    else $error("Isolate or duplex wrong after write.");
  a_ro_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (wr_ctrl && !wr_data[`PBM_CTRL_DUPLEX]) |=> ctrl_word[`PBM_CTRL_DUPLEX]
    && (isolate_o == $past(wr_data[`PBM_CTRL_ISO])))
    else $error("Read-only bit disturbed a write.");
endmodule

//--- tb/pbm_mdio_station.sv
// Station management controller model that sends serial management frames.
// Assumes a pull-up on the shared data wire and a testbench that resolves it.
`timescale 1ns/1ps
module pbm_mdio_station (
  input  wire logic ref_clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  localparam int HALF = 4;

  // Idle: released wire and a parked management clock.
  initial begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b0;
    mdio_oe_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One clock period: change data while low, sample at the rising edge.
  task automatic bit_cycle(input logic drive, input logic val, output logic smp);
    @(posedge ref_clk_i);
    mdc_o     <= 1'b0;
    mdio_oe_o <= drive;
    mdio_o    <= drive ? val : 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
    smp = mdio_i;
    mdc_o <= 1'b1;
    repeat (HALF - 1) @(posedge ref_clk_i);
  endtask

  // Whole frame with a full preamble; reads release the wire from turnaround on.
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] reg_a, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [13:0] hdr;
    logic        smp;
    logic        rd;
    hdr   = {2'b01, op, phy, reg_a};
    rd    = (op == 2'h2);
    rdata = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, smp);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], smp);
    bit_cycle(!rd, 1'b1, smp);
    bit_cycle(!rd, 1'b0, smp);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(!rd, wdata[i], smp);
      rdata[i] = smp;
    end
    // A released bit lets the device drop its enable before the next preamble.
    bit_cycle(1'b0, 1'b0, smp);
    // Park the clock low so that no rising edge is left pending across a reset.
    @(posedge ref_clk_i);
    mdc_o <= 1'b0;
  endtask
endmodule

//--- tb/tb_phy_basic_mgmt_registers.sv
// Self-checking bench for the basic management register bank.
// Assumes pbm_cfg.svh on the include path and the station model beside it.
`timescale 1ns/1ps
`include "pbm_cfg.svh"
module tb_phy_basic_mgmt_registers;
  localparam logic [4:0]  MY_ADDR = 5'h05;
  localparam logic [15:0] ID_H    = 16'hA5A5; // Arbitrary value.
  localparam logic [15:0] ID_L    = 16'h5A5A; // Arbitrary value.
  logic        ref_clk_i;
  logic        arst_n_i;
  logic        pd_strap;
  logic        autoneg_enable_bit;
  logic        an_done;
  logic        link_up;
  logic        rst_done;
  logic        mdc;
  logic        sta_out;
  logic        sta_oe;
  logic        dut_out;
  logic        dut_oe;
  logic        mdio_wire;
  logic        soft_rst;
  logic        pcs_loop;
  logic        soft_pd;
  logic        iso;
  logic        ext_wr;
  logic [15:0] ext_ctrl;
  logic [15:0] ext_data;
  logic [15:0] junk;
  int          fail_count;
  int          samples_checked;
  int          wr_pulses;

  // Pull-up wins whenever neither side drives the shared data wire.
  assign mdio_wire = dut_oe ? dut_out : (sta_oe ? sta_out : 1'b1);

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Counts write pulses toward the extended register device.
  always @(posedge ref_clk_i) begin
    if (ext_wr === 1'b1) wr_pulses++;
  end

  pbm_phy_basic_mgmt #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) DUT (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .mdc_i(mdc), .mdio_i(mdio_wire),
    .mdio_o(dut_out), .mdio_oe_o(dut_oe), .phy_addr_i(MY_ADDR),
    .pd_strap_i(pd_strap), .autoneg_enable_bit_i(autoneg_enable_bit), .an_complete_i(an_done),
    .link_up_i(link_up), .core_reset_done_i(rst_done),
    .core_soft_reset_bit_o(soft_rst), .pcs_loop_enable_bit_o(pcs_loop),
    .core_soft_power_down_bit_o(soft_pd), .isolate_o(iso),
    .ext_ctrl_o(ext_ctrl), .ext_data_o(ext_data), .ext_data_wr_o(ext_wr)
  );

  pbm_mdio_station u_sta (
    .ref_clk_i(ref_clk_i), .mdio_i(mdio_wire), .mdc_o(mdc), .mdio_o(sta_out),
    .mdio_oe_o(sta_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t pin %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_sta.xfer(`PBM_OP_WRITE, MY_ADDR, a, d, junk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] got;
    u_sta.xfer(`PBM_OP_READ, MY_ADDR, a, 16'h0000, got);
    chk_reg(got, exp);
  endtask

  // Reset is held six cycles; the strap is settled before release.
  task automatic do_reset(input logic strap);
    arst_n_i <= 1'b0;
    pd_strap <= strap;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i = 1'b0;
    pd_strap = 1'b0;
    autoneg_enable_bit    = 1'b1;
    an_done  = 1'b0;
    link_up  = 1'b0;
    rst_done = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    wr_pulses = 0;
    do_reset(1'b0);
    chk_pin(soft_pd, 1'b0, "pd");
    rd_chk(`PBM_REG_CTRL, 16'h1100);
    rd_chk(`PBM_REG_STAT, 16'h1009);
    rd_chk(`PBM_REG_ID_HIGH, ID_H);
    rd_chk(`PBM_REG_ID_LOW, ID_L);
    rd_chk(`PBM_REG_EXT_CTRL, 16'h0000);
    rd_chk(`PBM_REG_EXT_DATA, 16'h0000);
    rd_chk(5'h05, 16'h0000);
    @(posedge ref_clk_i);
    an_done <= 1'b1;
    link_up <= 1'b1;
    rd_chk(`PBM_REG_STAT, 16'h102D);
    wr(`PBM_REG_CTRL, 16'h4000);
    chk_pin(pcs_loop, 1'b1, "loop");
    rd_chk(`PBM_REG_CTRL, 16'h5100);
    // Frames for another station address or with a bad opcode are dropped.
    u_sta.xfer(`PBM_OP_WRITE, MY_ADDR ^ 5'h01, `PBM_REG_CTRL, 16'h0000, junk);
    u_sta.xfer(2'h3, MY_ADDR, `PBM_REG_CTRL, 16'h0000, junk);
    rd_chk(`PBM_REG_CTRL, 16'h5100);
    // All read-only bits set in one write; only writable ones may land.
    wr(`PBM_REG_CTRL, 16'h7FFF);
    rd_chk(`PBM_REG_CTRL, 16'h5D00);
    chk_pin(soft_pd, 1'b1, "pd");
    chk_pin(iso, 1'b1, "iso");
    chk_pin(soft_rst, 1'b0, "rst");
    // Management access keeps working in power-down.
    wr(`PBM_REG_EXT_CTRL, 16'hABCD);
    wr(`PBM_REG_EXT_DATA, 16'h1234);
    chk_reg(ext_ctrl, 16'hABCD);
    chk_reg(ext_data, 16'h1234);
    chk_reg(16'(wr_pulses), 16'h0001);
    rd_chk(`PBM_REG_EXT_CTRL, 16'hABCD);
    rd_chk(`PBM_REG_EXT_DATA, 16'h1234);
    wr(`PBM_REG_ID_HIGH, 16'hFFFF);
    rd_chk(`PBM_REG_ID_HIGH, ID_H);
    @(posedge ref_clk_i);
    autoneg_enable_bit <= 1'b0;
    rd_chk(`PBM_REG_CTRL, 16'h4D00);
    // Soft reset stays up through a zero write until the core reports done.
    wr(`PBM_REG_CTRL, 16'h8000);
    chk_pin(soft_rst, 1'b1, "rst");
    chk_pin(soft_pd, 1'b0, "pd");
    chk_pin(iso, 1'b0, "iso");
    wr(`PBM_REG_CTRL, 16'h0000);
    rd_chk(`PBM_REG_CTRL, 16'h8100);
    @(posedge ref_clk_i);
    rst_done <= 1'b1;
    @(posedge ref_clk_i);
    rst_done <= 1'b0;
    @(posedge ref_clk_i);
    chk_pin(soft_rst, 1'b0, "rst");
    rd_chk(`PBM_REG_CTRL, 16'h0100);
    autoneg_enable_bit <= 1'b1;
    do_reset(1'b1);
    chk_pin(soft_pd, 1'b1, "pd");
    rd_chk(`PBM_REG_CTRL, 16'h1900);
    rd_chk(`PBM_REG_EXT_CTRL, 16'h0000);
    complete_run();
  end
endmodule
